/* File: core/bctl_regs.svh */
// How it works
// - control bit 0 drives SDA low, reads 0
// - control bit 1 releases SDA, reads 1
// - control bit changes only with guard cleared
// - bit 3 shows level driven on SCL
// - reserved bits 2 and 0 read 1
// - bit 1 resets protocol logic, keeps registers
// - after reset: part reset 0, guard/monitor 1
`ifndef BCTL_REGS_SVH
`define BCTL_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define BCTL_OFF_CONTROL_TWO 12'h000
`define BCTL_OFF_PIN_STATUS 12'h004

// ----------------------------------------------------------------
// bus_control_two field positions
// ----------------------------------------------------------------
`define BCTL_BIT_SDA_LEVEL_CTL 5
`define BCTL_BIT_SDA_LEVEL_GUARD 4
`define BCTL_BIT_SCL_LEVEL_MONITOR 3
`define BCTL_BIT_RSVD_HI 2
`define BCTL_BIT_CTRL_PART_RESET 1
`define BCTL_BIT_RSVD_LO 0

// ----------------------------------------------------------------
// pin status field positions
// ----------------------------------------------------------------
`define BCTL_BIT_SDA_IN 0
`define BCTL_BIT_SCL_IN 1
`define BCTL_BIT_PART_RST_ACTIVE 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BCTL_RST_SDA_LEVEL_CTL 1'b1
`define BCTL_RST_CTRL_PART_RESET 1'b0
`define BCTL_RST_SCL_OE 1'b0
`define BCTL_RST_SDA_OE 1'b0
`define BCTL_RST_PRDATA 32'h0000_0000

`endif

/* File: core/bctl_pkg.sv */
package bctl_pkg;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [7:0] bctl_byte_t;
    typedef logic [31:0] bctl_word_t;

    // register selected by the current apb address
    typedef enum logic [1:0] {
        BCTL_SEL_NONE = 2'b00,
        BCTL_SEL_CONTROL_TWO = 2'b01,
        BCTL_SEL_PIN_STATUS = 2'b10
    } bctl_sel_t;

endpackage : bctl_pkg

/* File: core/bctl_rst_sync.sv */
`timescale 1ns/1ps

module bctl_rst_sync (
    // clock and raw reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // released reset
    output logic rst_sync_n
);

    logic meta_ff;
    logic hold_ff;

    // ------------------------------------------------------------
    // two stage release, asynchronous assertion
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            meta_ff <= 1'b1;
            hold_ff <= meta_ff;
        end
    end

    assign rst_sync_n = hold_ff;

endmodule : bctl_rst_sync

/* File: core/bctl_pin_ctl.sv */
`timescale 1ns/1ps
`include "bctl_regs.svh"

module bctl_pin_ctl (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // protocol engine side
    input wire logic eng_sda_low,
    input wire logic eng_scl_low,
    output logic ctrl_part_reset,
    // sda open-drain pin
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // scl open-drain pin
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_sync_n;

    bctl_rst_sync u_rst_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .rst_sync_n(rst_sync_n)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic sda_level_ctl_ff;
    logic nxt_sda_level_ctl;
    logic ctrl_part_reset_ff;
    logic nxt_ctrl_part_reset;
    logic sda_oe_ff;
    logic nxt_sda_oe;
    logic scl_oe_ff;
    logic nxt_scl_oe;
    logic sda_in_ff;
    logic scl_in_ff;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    bctl_pkg::bctl_sel_t reg_sel;
    wire hit_ctl = (paddr == `BCTL_OFF_CONTROL_TWO);
    wire hit_pin = (paddr == `BCTL_OFF_PIN_STATUS);
    wire access_ok = psel & penable & clk_en;
    wire wr_fire = access_ok & pwrite;
    wire wr_ctl = wr_fire & hit_ctl & pstrb[0];
    wire guard_open = ~pwdata[`BCTL_BIT_SDA_LEVEL_GUARD];

    assign reg_sel = hit_ctl ? bctl_pkg::BCTL_SEL_CONTROL_TWO :
                     hit_pin ? bctl_pkg::BCTL_SEL_PIN_STATUS :
                     bctl_pkg::BCTL_SEL_NONE;

    // answer in the first access cycle unless frozen
    assign pready = psel & penable & clk_en;
    assign pslverr = pready & (reg_sel == bctl_pkg::BCTL_SEL_NONE);
    assign prdata = prdata_ff;

    // ------------------------------------------------------------
    // register write paths
    // ------------------------------------------------------------
    // sda control moves only when the guard bit is written as 0
    assign nxt_sda_level_ctl = (wr_ctl & guard_open) ?
        pwdata[`BCTL_BIT_SDA_LEVEL_CTL] : sda_level_ctl_ff;
    // part reset stays until software writes it back to 0
    assign nxt_ctrl_part_reset = wr_ctl ?
        pwdata[`BCTL_BIT_CTRL_PART_RESET] : ctrl_part_reset_ff;

    // ------------------------------------------------------------
    // pin drive: open drain, low only
    // ------------------------------------------------------------
    // control bit 0 pulls sda low whatever the engine does
    assign nxt_sda_oe = ~nxt_sda_level_ctl |
        (eng_sda_low & ~nxt_ctrl_part_reset);
    // part reset drops the engine's hold on scl
    assign nxt_scl_oe = eng_scl_low & ~nxt_ctrl_part_reset;

    assign sda_o = 1'b0;
    assign scl_o = 1'b0;
    assign sda_oe = sda_oe_ff;
    assign scl_oe = scl_oe_ff;
    assign ctrl_part_reset = ctrl_part_reset_ff;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    bctl_pkg::bctl_byte_t ctl_rd;
    bctl_pkg::bctl_byte_t pin_rd;

    assign ctl_rd = {
        2'b00,
        sda_level_ctl_ff,
        1'b1,
        ~scl_oe_ff,
        1'b1,
        ctrl_part_reset_ff,
        1'b1
    };

    assign pin_rd = {5'b0_0000, ctrl_part_reset_ff, scl_in_ff, sda_in_ff};

    assign nxt_prdata = (reg_sel == bctl_pkg::BCTL_SEL_CONTROL_TWO) ? {24'h00_0000, ctl_rd} :
                        (reg_sel == bctl_pkg::BCTL_SEL_PIN_STATUS) ? {24'h00_0000, pin_rd} :
                        `BCTL_RST_PRDATA;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sda_level_ctl_ff <= `BCTL_RST_SDA_LEVEL_CTL;
            ctrl_part_reset_ff <= `BCTL_RST_CTRL_PART_RESET;
        end else if (clk_en) begin
            sda_level_ctl_ff <= nxt_sda_level_ctl;
            ctrl_part_reset_ff <= nxt_ctrl_part_reset;
        end
    end

    // pin drivers, released at reset so scl monitor reads 1
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sda_oe_ff <= `BCTL_RST_SDA_OE;
            scl_oe_ff <= `BCTL_RST_SCL_OE;
        end else if (clk_en) begin
            sda_oe_ff <= nxt_sda_oe;
            scl_oe_ff <= nxt_scl_oe;
        end
    end

    // sampled pin levels and read data
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sda_in_ff <= 1'b1;
            scl_in_ff <= 1'b1;
            prdata_ff <= `BCTL_RST_PRDATA;
        end else if (clk_en) begin
            sda_in_ff <= sda_i;
            scl_in_ff <= scl_i;
            prdata_ff <= nxt_prdata;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // sda control at 0 means the pin is pulled low next cycle
    AST_SDA_LOW_ON_ZERO: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && !nxt_sda_level_ctl) |=> (sda_oe && !ctl_rd[5]))
        else $error("sda not driven low while control bit is 0");

    // a guarded-open write of 1 sets the bit and reads back 1
    AST_SDA_RELEASE_WRITE: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (wr_ctl && guard_open && pwdata[5]) |=> (sda_level_ctl_ff && ctl_rd[5]))
        else $error("sda control did not take written 1");

    // guard set leaves the control bit unchanged
    AST_GUARD_BLOCKS: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (wr_ctl && !guard_open) |=> $stable(sda_level_ctl_ff))
        else $error("sda control changed with guard set");

    // guard reads 1 whatever was written
    AST_GUARD_READS_ONE: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (rst_sync_n && clk_en && hit_ctl) |=> prdata[4])
        else $error("guard bit read as 0");

    // monitor follows the scl driver one cycle later
    AST_SCL_MONITOR: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (rst_sync_n && clk_en && hit_ctl) |=> (prdata[3] == ~$past(scl_oe_ff)))
        else $error("scl monitor disagrees with scl drive");

    // reserved bits read 1
    AST_RSVD_ONES: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (rst_sync_n && clk_en && hit_ctl) |=> (prdata[2] && prdata[0]))
        else $error("reserved bit read as 0");

    // part reset frees scl and keeps register contents
    AST_PART_RESET_KEEPS: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && ctrl_part_reset_ff && !wr_ctl) |=>
            (!scl_oe_ff && $stable(sda_level_ctl_ff)))
        else $error("part reset lost state or held scl");

    // values right after reset release
    AST_RESET_VALUES: assert property (
        @(posedge sys_clk)
        $rose(rst_sync_n) |-> (!ctrl_part_reset_ff && ctl_rd[4] && ctl_rd[3]))
        else $error("wrong values after reset");

    // part reset holds until a write clears it
    AST_PART_RESET_HOLDS: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (ctrl_part_reset_ff && !wr_ctl) |=> ctrl_part_reset_ff)
        else $error("part reset released without a write");

    // a write of 0 releases the part reset
    AST_PART_RESET_RELEASE: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (wr_ctl && !pwdata[1]) |=> !ctrl_part_reset)
        else $error("part reset not released by write of 0");

    // a write of 1 starts the part reset
    AST_PART_RESET_SET: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (wr_ctl && pwdata[1]) |=> ctrl_part_reset)
        else $error("part reset not started by write of 1");

    // part reset with control bit 1 lets sda go
    AST_PART_RESET_FREES_SDA: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && nxt_ctrl_part_reset && nxt_sda_level_ctl) |=> !sda_oe)
        else $error("sda still driven during part reset");

    // outside part reset the engine may pull sda low
    AST_SDA_ENGINE: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && eng_sda_low && !nxt_ctrl_part_reset) |=> sda_oe)
        else $error("engine hold on sda not passed to the pin");

    // outside part reset the engine may pull scl low
    AST_SCL_ENGINE: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && eng_scl_low && !nxt_ctrl_part_reset) |=> scl_oe)
        else $error("engine hold on scl not passed to the pin");

    // frozen clock enable holds the control bits
    AST_FREEZE_CTL: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        !clk_en |=> ($stable(sda_level_ctl_ff) && $stable(ctrl_part_reset_ff)))
        else $error("control bits moved while clock enable low");

    // frozen clock enable holds both pin drivers
    AST_FREEZE_PINS: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        !clk_en |=> ($stable(sda_oe) && $stable(scl_oe)))
        else $error("pin driver moved while clock enable low");

    // frozen clock enable holds the read data
    AST_FREEZE_RDATA: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        !clk_en |=> $stable(prdata))
        else $error("read data moved while clock enable low");

    // unmapped access answers with an error
    AST_UNMAPPED_ERR: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (psel && penable && clk_en && !hit_ctl && !hit_pin) |-> pslverr)
        else $error("unmapped access without error");

    // a write elsewhere leaves the control bits alone
    AST_UNMAPPED_NO_WRITE: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (wr_fire && !hit_ctl) |=> ($stable(sda_level_ctl_ff) && $stable(ctrl_part_reset_ff)))
        else $error("control bits moved on a write elsewhere");

    // a write with the low byte lane off is ignored
    AST_STRB_OFF_NO_WRITE: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (wr_fire && !pstrb[0]) |=> ($stable(sda_level_ctl_ff) && $stable(ctrl_part_reset_ff)))
        else $error("control bits moved with byte lane off");

    // pin status shows sampled pins and part reset
    AST_PIN_STATUS: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (rst_sync_n && clk_en && hit_pin) |=>
            (prdata[2:0] == {$past(ctrl_part_reset_ff), $past(scl_in_ff), $past(sda_in_ff)}))
        else $error("pin status read disagrees with pins");

    // upper read bits stay 0
    AST_UPPER_ZERO: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        clk_en |=> (prdata[31:6] == 26'h000_0000))
        else $error("upper read bits not 0");

    // both pins are only ever pulled low, never driven high
    AST_OPEN_DRAIN_ZERO: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (!sda_o && !scl_o))
        else $error("pin output value not low");

endmodule : bctl_pin_ctl

/* File: core/placeholder_none.sv */
`timescale 1ns/1ps

/* File: tb/bctl_bus_model.sv */
`timescale 1ns/1ps

module bctl_bus_model (
    // open-drain drivers of the block
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic scl_o,
    input wire logic scl_oe,
    // far-side devices pulling a line low
    input wire logic dev_sda_low,
    input wire logic dev_scl_low,
    // resolved line levels
    output logic sda_line,
    output logic scl_line
);
    // wired-and with pull-up: a released line floats high
    assign sda_line = ~((sda_oe & ~sda_o) | dev_sda_low);
    assign scl_line = ~((scl_oe & ~scl_o) | dev_scl_low);
endmodule : bctl_bus_model

/* File: tb/tb.sv */
`timescale 1ns/1ps

module tb;
    // one table row: stimulus beside expected outputs
    typedef struct packed {
        logic [7:0] wr;
        logic esda;
        logic escl;
        logic [7:0] rd;
        logic soe;
        logic coe;
        logic prst;
    } bctl_row_t;
    logic sys_clk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic eng_sda_low, eng_scl_low, ctrl_part_reset, dev_sda_low, dev_scl_low;
    logic sda_i, sda_o, sda_oe, scl_i, scl_o, scl_oe;
    int n_fail, checks_done;
    bctl_row_t rows [7];

    bctl_pin_ctl dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .eng_sda_low(eng_sda_low),
        .eng_scl_low(eng_scl_low), .ctrl_part_reset(ctrl_part_reset), .sda_i(sda_i),
        .sda_o(sda_o), .sda_oe(sda_oe), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe));

    bctl_bus_model bm (.sda_o(sda_o), .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe),
        .dev_sda_low(dev_sda_low), .dev_scl_low(dev_scl_low), .sda_line(sda_i),
        .scl_line(scl_i));

    // 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // word and bit comparisons
    task automatic chk32(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk32

    task automatic chk1(input string nm, input logic ex, input logic got);
        checks_done++;
        if (got !== ex) begin
            n_fail++;
            $display("FAIL %s expected %b seen %b", nm, ex, got);
        end
    endtask : chk1

    // one apb transfer, waiting for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk1("pready", 1'b1, pready);
            close_out();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    // verdict and end of run
    task automatic close_out();
        if (n_fail == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        close_out();
    end

    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, eng_sda_low, eng_scl_low} = '0;
        {dev_sda_low, dev_scl_low} = '0;
        clk_en = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        n_fail = 0;
        checks_done = 0;
        rows[0] = {8'h00, 1'b0, 1'b0, 8'h1d, 1'b1, 1'b0, 1'b0};
        rows[1] = {8'h20, 1'b0, 1'b0, 8'h3d, 1'b0, 1'b0, 1'b0};
        rows[2] = {8'h10, 1'b0, 1'b0, 8'h3d, 1'b0, 1'b0, 1'b0};
        rows[3] = {8'h00, 1'b0, 1'b0, 8'h1d, 1'b1, 1'b0, 1'b0};
        rows[4] = {8'h30, 1'b0, 1'b0, 8'h1d, 1'b1, 1'b0, 1'b0};
        rows[5] = {8'h20, 1'b0, 1'b1, 8'h35, 1'b0, 1'b1, 1'b0};
        rows[6] = {8'h12, 1'b1, 1'b1, 8'h3f, 1'b0, 1'b0, 1'b1};
        repeat (16) @(posedge sys_clk);
        chk1("sda_oe", 1'b0, sda_oe);
        chk1("ctrl_part_reset", 1'b0, ctrl_part_reset);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk32("ctl2", 32'h0000_003d, rd);
        foreach (rows[i]) begin
            eng_sda_low <= rows[i].esda;
            eng_scl_low <= rows[i].escl;
            apb(1'b1, 12'h000, {24'h00_0000, rows[i].wr});
            repeat (2) @(posedge sys_clk);
            chk1("sda_oe", rows[i].soe, sda_oe);
            chk1("scl_oe", rows[i].coe, scl_oe);
            chk1("ctrl_part_reset", rows[i].prst, ctrl_part_reset);
            apb(1'b0, 12'h000, 32'h0000_0000);
            chk32("ctl2", {24'h00_0000, rows[i].rd}, rd);
        end
        // part reset held over many cycles, then released
        apb(1'b1, 12'h000, 32'h0000_0002);
        repeat (20) @(posedge sys_clk);
        chk1("ctrl_part_reset", 1'b1, ctrl_part_reset);
        chk1("sda_oe", 1'b1, sda_oe);
        chk1("scl_oe", 1'b0, scl_oe);
        apb(1'b1, 12'h000, 32'h0000_0020);
        repeat (2) @(posedge sys_clk);
        chk1("ctrl_part_reset", 1'b0, ctrl_part_reset);
        chk1("scl_oe", 1'b1, scl_oe);
        // far side holds scl low; status shows pin levels
        eng_sda_low <= 1'b0;
        eng_scl_low <= 1'b0;
        dev_scl_low <= 1'b1;
        repeat (4) @(posedge sys_clk);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk32("pin_status", 32'h0000_0001, rd);
        dev_scl_low <= 1'b0;
        // unmapped access and disabled byte lane leave the register alone
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk1("pslverr", 1'b1, er);
        chk32("unmapped", 32'h0000_0000, rd);
        apb(1'b1, 12'h008, 32'h0000_0000);
        pstrb <= 4'h0;
        apb(1'b1, 12'h000, 32'h0000_0000);
        pstrb <= 4'hf;
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk32("ctl2", 32'h0000_003d, rd);
        // clock enable low freezes the drivers; pins only ever pull low
        clk_en <= 1'b0;
        eng_scl_low <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk1("scl_oe", 1'b0, scl_oe);
        chk1("sda_o", 1'b0, sda_o);
        chk1("scl_o", 1'b0, scl_o);
        clk_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk1("scl_oe", 1'b1, scl_oe);
        eng_scl_low <= 1'b0;
        // second reset in mid-run restores defaults
        apb(1'b1, 12'h000, 32'h0000_0000);
        @(posedge sys_clk);
        chk1("sda_oe", 1'b1, sda_oe);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk1("sda_oe", 1'b0, sda_oe);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk32("ctl2", 32'h0000_003d, rd);
        close_out();
    end
endmodule : tb
